// ### irqmg_top.sv
// Operation
// - mask readable at both set and clear
// - gate bit zero blocks external interrupt
// - custom source needs mask and event 30
// - other mask bits gate matching event bits
// - reserved mask positions read zero
// - bits 26, 19 gate transceiver events
// - bits 25, 23, 22 gate cycle faults
// - bits 21, 20 gate cycle timing
// - bit 24 gates fatal error
// - bits 17, 16 gate bus reinit events
// - bits 9, 8 gate lock, posted errors
// - bits 7, 6 gate isochronous dma
// - bits 5, 4 gate stored packets
// - bits 3, 2 gate receive dma
// - bits 1, 0 gate send completions
// - gate bit also hardware updatable
// - write ones set or clear, zeros keep
// - iso summary is OR of masked contexts
`timescale 1ns/1ps
`default_nettype none
`include "irqmg_map.svh"

module irqmg_top
    import irqmg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // interrupt event sources
    input wire logic [31:0] event_vec,
    input wire logic [`IRQMG_ISO_TX_CTX-1:0] iso_tx_ev,
    input wire logic [`IRQMG_ISO_TX_CTX-1:0] iso_tx_mk,
    input wire logic [`IRQMG_ISO_RX_CTX-1:0] iso_rx_ev,
    input wire logic [`IRQMG_ISO_RX_CTX-1:0] iso_rx_mk,
    input wire logic gate_hw_clr,
    // interrupt out
    output logic irq
);
    // ==========================================================
    // address decode helper
    function automatic logic addr_is(input logic [31:0] a,
                                     input logic [11:0] off);
        addr_is = (a[11:2] == off[11:2]);
    endfunction

    irqmg_gate_if gif (.sys_clk(sys_clk), .rst(rst));

    irqmg_word_t mask_q;
    irqmg_word_t mask_d;
    irqmg_word_t hrdata_q;
    irqmg_word_t hrdata_d;
    irqmg_dphase_s dp_q;
    irqmg_dphase_s dp_d;
    logic irq_q;

    wire logic addr_phase;
    wire logic hit_set;
    wire logic hit_clr;
    wire logic hit_pend;
    wire logic word_wr;
    wire irqmg_word_t wr_set;
    wire irqmg_word_t wr_clr;
    wire irqmg_word_t after_hw;
    wire irqmg_word_t pend_view;

    // ==========================================================
    // address phase capture
    assign addr_phase = hsel & hready & (htrans == `IRQMG_HTRANS_NONSEQ);
    assign hit_set = addr_is(haddr, `IRQMG_OFF_MASK_SET);
    assign hit_clr = addr_is(haddr, `IRQMG_OFF_MASK_CLR);
    assign hit_pend = addr_is(haddr, `IRQMG_OFF_PEND_VIEW);
    // sub-word writes are dropped rather than half-applied
    assign word_wr = addr_phase & hwrite & (hsize == `IRQMG_HSIZE_WORD);

    always_comb begin
        dp_d.write = word_wr;
        dp_d.acc = IRQMG_ACC_NONE;
        if (word_wr && hit_set) begin
            dp_d.acc = IRQMG_ACC_SET;
        end else if (word_wr && hit_clr) begin
            dp_d.acc = IRQMG_ACC_CLR;
        end
    end

    // ==========================================================
    // mask update: hw clear, then sw clear, then sw set
    assign wr_set = (dp_q.acc == IRQMG_ACC_SET) ? hwdata : 32'h0000_0000;
    assign wr_clr = (dp_q.acc == IRQMG_ACC_CLR) ? hwdata : 32'h0000_0000;
    assign after_hw = gate_hw_clr ?
        (mask_q & ~(32'h0000_0001 << `IRQMG_BIT_GATE)) : mask_q;
    // a set in the same cycle as a hardware clear wins
    assign mask_d = ((after_hw & ~wr_clr) | wr_set)
        & `IRQMG_MASK_IMPL;

    // ==========================================================
    // read data is registered in the address phase; mask_d is used
    // so a write in the previous data phase is already visible
    assign pend_view = gif.pend | {gif.irq_req, 31'h0000_0000};

    always_comb begin
        hrdata_d = 32'h0000_0000;
        if (addr_phase && !hwrite && (hit_set || hit_clr)) begin
            hrdata_d = mask_d;
        end else if (addr_phase && !hwrite && hit_pend) begin
            hrdata_d = pend_view;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask_q <= `IRQMG_MASK_RESET;
            dp_q <= '{write: 1'b0, acc: IRQMG_ACC_NONE};
            hrdata_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            dp_q <= dp_d;
            hrdata_q <= hrdata_d;
            irq_q <= gif.irq_req;
        end
    end

    // ==========================================================
    // gating logic
    assign gif.mask = mask_q;
    assign gif.event_vec = event_vec;
    assign gif.iso_tx_ev = iso_tx_ev;
    assign gif.iso_tx_mk = iso_tx_mk;
    assign gif.iso_rx_ev = iso_rx_ev;
    assign gif.iso_rx_mk = iso_rx_mk;

    irqmg_gate u_gate (.g(gif.gate));

    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign irq = irq_q;

    // ==========================================================
    // checks
    reserved_zero_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (hrdata & ~`IRQMG_MASK_IMPL & 32'h7FFF_FFFF) == 32'h0000_0000)
    else $error("reserved mask bits read nonzero");

    read_mask_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (addr_phase && !hwrite && (hit_set || hit_clr))
        |=> (hrdata == mask_q))
    else $error("mask read does not match mask");

    gate_off_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !mask_q[`IRQMG_BIT_GATE] |=> !irq)
    else $error("interrupt raised with gate off");

    irq_cause_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ##1 irq == $past(mask_q[`IRQMG_BIT_GATE] & (|gif.pend)))
    else $error("interrupt not tied to masked event");

    set_write_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dp_q.acc == IRQMG_ACC_SET)
        |=> ((mask_q & $past(hwdata)) == ($past(hwdata) & `IRQMG_MASK_IMPL)))
    else $error("set write did not set bits");

    clr_write_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dp_q.acc == IRQMG_ACC_CLR) |=> ((mask_q & $past(hwdata)) == 0))
    else $error("clear write did not clear bits");

    zero_keep_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dp_q.acc != IRQMG_ACC_NONE) && !gate_hw_clr
        |=> (((mask_q ^ $past(mask_q)) & ~$past(hwdata)) == 0))
    else $error("written zero changed a mask bit");

    hw_gate_clr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        gate_hw_clr && !(wr_set[`IRQMG_BIT_GATE])
        |=> !mask_q[`IRQMG_BIT_GATE] ##1 !irq)
    else $error("hardware gate clear ignored");
endmodule

`default_nettype wire

// ### irqmg_map.svh
`ifndef IRQMG_MAP_SVH
`define IRQMG_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define IRQMG_OFF_MASK_SET 12'h088
`define IRQMG_OFF_MASK_CLR 12'h08C
`define IRQMG_OFF_PEND_VIEW 12'h100

// ==========================================================
// mask field layout
`define IRQMG_BIT_GATE 31
`define IRQMG_BIT_CUSTOM 30
`define IRQMG_MASK_IMPL 32'hC7FB_03FF
`define IRQMG_MASK_SRC 32'h47FB_03FF
`define IRQMG_MASK_RESET 32'h0000_0000

// ==========================================================
// isochronous context counts and bus constants
`define IRQMG_ISO_TX_CTX 8
`define IRQMG_ISO_RX_CTX 4
`define IRQMG_HSIZE_WORD 3'h2
`define IRQMG_HTRANS_NONSEQ 2'h2

`endif

// ### irqmg_pkg.sv
package irqmg_pkg;

    typedef logic [31:0] irqmg_word_t;

    typedef enum logic [1:0] {
        IRQMG_ACC_NONE,
        IRQMG_ACC_SET,
        IRQMG_ACC_CLR
    } irqmg_acc_e;

    typedef struct packed {
        logic write;
        irqmg_acc_e acc;
    } irqmg_dphase_s;

endpackage

// ### irqmg_gate_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "irqmg_map.svh"

interface irqmg_gate_if (
    input wire logic sys_clk,
    input wire logic rst
);
    logic [31:0] mask;
    logic [31:0] event_vec;
    logic [`IRQMG_ISO_TX_CTX-1:0] iso_tx_ev;
    logic [`IRQMG_ISO_TX_CTX-1:0] iso_tx_mk;
    logic [`IRQMG_ISO_RX_CTX-1:0] iso_rx_ev;
    logic [`IRQMG_ISO_RX_CTX-1:0] iso_rx_mk;
    logic [31:0] pend;
    logic irq_req;

    modport ctrl (
        input sys_clk, rst, pend, irq_req,
        output mask, event_vec, iso_tx_ev, iso_tx_mk, iso_rx_ev, iso_rx_mk
    );
    modport gate (
        input sys_clk, rst, mask, event_vec,
        input iso_tx_ev, iso_tx_mk, iso_rx_ev, iso_rx_mk,
        output pend, irq_req
    );
endinterface

`default_nettype wire

// ### irqmg_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "irqmg_map.svh"

module irqmg_gate
    import irqmg_pkg::*;
(
    // link to the register side
    irqmg_gate_if.gate g
);
    wire logic iso_tx_any;
    wire logic iso_rx_any;
    wire logic [31:0] ev_w;
    wire logic [31:0] hit_w;

    // ==========================================================
    // isochronous summary bits are live, never latched
    assign iso_tx_any = |(g.iso_tx_ev & g.iso_tx_mk);
    assign iso_rx_any = |(g.iso_rx_ev & g.iso_rx_mk);
    assign ev_w = {g.event_vec[31:8], iso_rx_any, iso_tx_any,
                   g.event_vec[5:0]};

    // ==========================================================
    // per-source gating, mask bit against event bit
    assign hit_w[31] = 1'b0;
    assign hit_w[30] = ev_w[30] & g.mask[30];
    assign hit_w[29:27] = 3'h0;
    assign hit_w[26] = ev_w[26] & g.mask[26];
    assign hit_w[25] = ev_w[25] & g.mask[25];
    assign hit_w[24] = ev_w[24] & g.mask[24];
    assign hit_w[23:22] = ev_w[23:22] & g.mask[23:22];
    assign hit_w[21:20] = ev_w[21:20] & g.mask[21:20];
    assign hit_w[19] = ev_w[19] & g.mask[19];
    assign hit_w[18] = 1'b0;
    assign hit_w[17:16] = ev_w[17:16] & g.mask[17:16];
    assign hit_w[15:10] = 6'h00;
    assign hit_w[9:8] = ev_w[9:8] & g.mask[9:8];
    assign hit_w[7:6] = ev_w[7:6] & g.mask[7:6];
    assign hit_w[5:4] = ev_w[5:4] & g.mask[5:4];
    assign hit_w[3:2] = ev_w[3:2] & g.mask[3:2];
    assign hit_w[1:0] = ev_w[1:0] & g.mask[1:0];
    assign g.pend = hit_w & `IRQMG_MASK_SRC;

    // the gate bit only enables; it is never a source itself
    assign g.irq_req = g.mask[`IRQMG_BIT_GATE] & (|g.pend);

    // ==========================================================
    // checks
    custom_src_a: assert property (
        @(posedge g.sys_clk) disable iff (g.rst)
        g.pend[30] == (g.mask[30] & g.event_vec[30]))
    else $error("custom source gating wrong");

    iso_or_a: assert property (
        @(posedge g.sys_clk) disable iff (g.rst)
        g.pend[7] == (g.mask[7] & (|(g.iso_rx_ev & g.iso_rx_mk))))
    else $error("iso receive summary wrong");

    src_gate_a: assert property (
        @(posedge g.sys_clk) disable iff (g.rst)
        (g.pend & ~(g.mask & `IRQMG_MASK_SRC)) == 32'h0000_0000)
    else $error("pending without its mask bit");
endmodule

`default_nettype wire

// ### irq_mask_gate_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "irqmg_map.svh"

module irq_mask_gate_test
    import irqmg_pkg::*;
();
// ==========================================================
// stimulus and observed signals
logic sys_clk, rst, hsel, hwrite, gate_hw_clr;
logic [31:0] haddr;
irqmg_word_t hwdata, event_vec, hrdata, rd_smp, rd;
logic [1:0] htrans;
logic [2:0] hsize;
logic hreadyout, hresp, irq;
logic [`IRQMG_ISO_TX_CTX-1:0] iso_tx_ev, iso_tx_mk;
logic [`IRQMG_ISO_RX_CTX-1:0] iso_rx_ev, iso_rx_mk;
wire logic hready;
int bad_count, n_compared;
localparam irqmg_word_t IMPL = `IRQMG_MASK_IMPL;
localparam irqmg_word_t GATE = 32'h8000_0000;

// single slave: its ready is the bus ready
assign hready = hreadyout;

irqmg_top i_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .event_vec(event_vec), .iso_tx_ev(iso_tx_ev), .iso_tx_mk(iso_tx_mk),
    .iso_rx_ev(iso_rx_ev), .iso_rx_mk(iso_rx_mk),
    .gate_hw_clr(gate_hw_clr), .irq(irq));

always #5 sys_clk = ~sys_clk;
// nonblocking copy keeps the pre-edge read data, free of races
always @(posedge sys_clk) rd_smp <= hrdata;

// ==========================================================
// shared tasks
task results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask

task check(input string what, input irqmg_word_t seen, input irqmg_word_t exp);
    n_compared++;
    if (seen !== exp) begin
        bad_count++;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
endtask

task wait_ready();
    int i;
    i = 0;
    do begin
        @(posedge sys_clk);
        i++;
    end while (hready !== 1'b1 && i < 50);
    if (hready !== 1'b1) begin
        bad_count++;
        $display("mismatch hready expected 1 seen %b", hready);
        results();
    end
endtask

task bus(input logic wr, input logic [31:0] a, input irqmg_word_t d,
         input logic [2:0] sz);
    @(posedge sys_clk);
    haddr <= a;
    htrans <= `IRQMG_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    #1 rd = rd_smp;
endtask

task wr(input logic [31:0] a, input irqmg_word_t d);
    bus(1'b1, a, d, `IRQMG_HSIZE_WORD);
endtask

task rd_chk(input logic [31:0] a, input irqmg_word_t exp);
    bus(1'b0, a, 32'h0000_0000, `IRQMG_HSIZE_WORD);
    check("mask read", rd, exp);
    check("hresp", {31'h0, hresp}, 32'h0000_0000);
endtask

task load_mask(input irqmg_word_t m);
    wr(`IRQMG_OFF_MASK_CLR, 32'hFFFF_FFFF);
    wr(`IRQMG_OFF_MASK_SET, m);
endtask

// irq is registered: two edges after the inputs change it has settled
task irq_chk(input irqmg_word_t ev, input logic [3:0] rxe,
             input logic [3:0] rxm, input logic [7:0] txe,
             input logic [7:0] txm, input logic e);
    @(posedge sys_clk);
    event_vec <= ev;
    iso_rx_ev <= rxe;
    iso_rx_mk <= rxm;
    iso_tx_ev <= txe;
    iso_tx_mk <= txm;
    repeat (2) @(posedge sys_clk);
    #1 check("irq", {31'h0, irq}, {31'h0, e});
endtask

// ==========================================================
// scenarios
task reg_access();
    load_mask(32'hFFFF_FFFF);
    rd_chk(`IRQMG_OFF_MASK_SET, IMPL);
    rd_chk(`IRQMG_OFF_MASK_CLR, IMPL);
    wr(`IRQMG_OFF_MASK_CLR, 32'h0000_0001);
    wr(`IRQMG_OFF_MASK_SET, 32'h0000_0000);
    rd_chk(`IRQMG_OFF_MASK_SET, IMPL & 32'hFFFF_FFFE);
    load_mask(32'h0000_0002);
    wr(`IRQMG_OFF_MASK_SET, 32'h0000_0001);
    rd_chk(`IRQMG_OFF_MASK_CLR, 32'h0000_0003);
    // unmapped place and a byte-wide write must leave the mask alone
    wr(12'h0C0, 32'hFFFF_FFFF);
    rd_chk(12'h0C0, 32'h0000_0000);
    bus(1'b1, `IRQMG_OFF_MASK_SET, 32'hFFFF_FFFF, 3'h0);
    rd_chk(`IRQMG_OFF_MASK_SET, 32'h0000_0003);
endtask

// one source bit: its own event fires, all others do not, gate blocks it
task gate_bit(input int i);
    irqmg_word_t b;
    b = 32'h0000_0001 << i;
    load_mask(GATE | b);
    irq_chk(b, 4'h0, 4'h0, 8'h00, 8'h00, 1'b1);
    irq_chk(~b, 4'h0, 4'h0, 8'h00, 8'h00, 1'b0);
    wr(`IRQMG_OFF_MASK_CLR, GATE);
    irq_chk(b, 4'h0, 4'h0, 8'h00, 8'h00, 1'b0);
endtask

task gate_each();
    gate_bit(30);
    gate_bit(26);
    gate_bit(25);
    gate_bit(24);
    gate_bit(23);
    gate_bit(22);
    gate_bit(21);
    gate_bit(20);
    gate_bit(19);
    gate_bit(17);
    gate_bit(16);
    gate_bit(9);
    gate_bit(8);
    gate_bit(5);
    gate_bit(4);
    gate_bit(3);
    gate_bit(2);
    gate_bit(1);
    gate_bit(0);
endtask

task iso_sum();
    load_mask(GATE | 32'h0000_00C0);
    irq_chk(32'h0000_00C0, 4'h0, 4'hF, 8'h00, 8'hFF, 1'b0);
    for (int k = 0; k < `IRQMG_ISO_RX_CTX; k++) begin
        irq_chk(0, 4'h1 << k, 4'h1 << k, 8'h00, 8'h00, 1'b1);
        irq_chk(0, 4'h1 << k, ~(4'h1 << k), 8'h00, 8'h00, 1'b0);
    end
    for (int k = 0; k < `IRQMG_ISO_TX_CTX; k++) begin
        irq_chk(0, 4'h0, 4'h0, 8'h01 << k, 8'h01 << k, 1'b1);
        irq_chk(0, 4'h0, 4'h0, 8'h01 << k, ~(8'h01 << k), 1'b0);
    end
    load_mask(GATE | 32'h0000_0040);
    irq_chk(0, 4'hF, 4'hF, 8'h00, 8'h00, 1'b0);
    load_mask(32'hFFFF_FFFF);
    irq_chk(~`IRQMG_MASK_SRC, 4'h0, 4'h0, 8'h00, 8'h00, 1'b0);
endtask

task hw_update();
    load_mask(GATE | 32'h0000_0001);
    irq_chk(32'h0000_0001, 4'h0, 4'h0, 8'h00, 8'h00, 1'b1);
    rd_chk(`IRQMG_OFF_PEND_VIEW, GATE | 32'h0000_0001);
    @(posedge sys_clk);
    gate_hw_clr <= 1'b1;
    @(posedge sys_clk);
    gate_hw_clr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 check("irq", {31'h0, irq}, 32'h0000_0000);
    rd_chk(`IRQMG_OFF_MASK_SET, 32'h0000_0001);
    // hardware clear lands in the data phase of a software set: set wins
    @(posedge sys_clk);
    haddr <= `IRQMG_OFF_MASK_SET;
    htrans <= `IRQMG_HTRANS_NONSEQ;
    hwrite <= 1'b1;
    hsize <= `IRQMG_HSIZE_WORD;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= GATE;
    gate_hw_clr <= 1'b1;
    wait_ready();
    gate_hw_clr <= 1'b0;
    rd_chk(`IRQMG_OFF_MASK_SET, GATE | 32'h0000_0001);
endtask

// reset in mid-run with the interrupt up, then software sets up again
task reset_mid();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1 check("irq after reset", {31'h0, irq}, 32'h0000_0000);
    bus(1'b0, `IRQMG_OFF_MASK_CLR, 32'h0000_0000, `IRQMG_HSIZE_WORD);
    check("reserved after reset", rd & ~IMPL, 32'h0000_0000);
    load_mask(GATE | 32'h0000_0001);
    irq_chk(32'h0000_0001, 4'h0, 4'h0, 8'h00, 8'h00, 1'b1);
endtask

// ==========================================================
// main sequence
initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `IRQMG_HSIZE_WORD;
    hwdata = 32'h0000_0000;
    event_vec = 32'h0000_0000;
    {iso_tx_ev, iso_tx_mk, iso_rx_ev, iso_rx_mk} = '0;
    gate_hw_clr = 1'b0;
    bad_count = 0;
    n_compared = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 check("irq after reset", {31'h0, irq}, 32'h0000_0000);
    reg_access();
    gate_each();
    iso_sum();
    hw_update();
    reset_mid();
    results();
end

endmodule
`default_nettype wire
